// File: common/jird_pkg.sv
`default_nettype none

package jird_pkg;

  // ----------------------------------------------------------------
  // Sizes of the scan path
  // ----------------------------------------------------------------
  localparam int IR_W = 3;
  localparam int PIN_IN_W = 8;
  localparam int PIN_OUT_W = 8;
  localparam int BSR_W = PIN_IN_W + PIN_OUT_W;

  // ----------------------------------------------------------------
  // Instruction codes and fixed load patterns
  // ----------------------------------------------------------------
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
  localparam logic [IR_W-1:0] IR_RESET_LOAD = 3'h1;
  localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] INS_SAMPLE = 3'h3;
  localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
  localparam logic BYPASS_CAPTURE = 1'b0;

  // ----------------------------------------------------------------
  // Test access port controller states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001,
    TAP_IDLE = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SHIFT_DR = 16'h0010,
    TAP_EXIT1_DR = 16'h0020,
    TAP_PAUSE_DR = 16'h0040,
    TAP_EXIT2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SHIFT_IR = 16'h0800,
    TAP_EXIT1_IR = 16'h1000,
    TAP_PAUSE_IR = 16'h2000,
    TAP_EXIT2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } jird_tap_e;

  // ----------------------------------------------------------------
  // State carried on the rising test clock edge
  // ----------------------------------------------------------------
  typedef struct packed {
    jird_tap_e tap;
    logic [IR_W-1:0] irShift;
    logic bypassBit;
    logic [BSR_W-1:0] bsr;
    logic [PIN_IN_W-1:0] inMeta;
    logic [PIN_IN_W-1:0] inSync;
    logic [PIN_OUT_W-1:0] outMeta;
    logic [PIN_OUT_W-1:0] outSync;
  } jird_rise_s;

  // ----------------------------------------------------------------
  // State carried on the falling test clock edge
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [IR_W-1:0] irLatch;
    logic extest;
    logic tdo;
    logic tdoOe;
    logic [PIN_OUT_W-1:0] updLatch;
    logic updToggle;
  } jird_fall_s;

  // ----------------------------------------------------------------
  // State carried on the system clock
  // ----------------------------------------------------------------
  typedef struct packed {
    logic modeMeta;
    logic modeSync;
    logic togMeta;
    logic togSync;
    logic togSeen;
    logic [PIN_OUT_W-1:0] held;
    logic [PIN_OUT_W-1:0] pinOut;
  } jird_sys_s;

endpackage

`default_nettype wire

// File: design/jird_top.sv
// Overview of operation
// - Latched instruction changes only in Update-IR, reset
// - Serial instruction bits pass without inversion
// - Capture-IR loads pattern 01 into shift stage
// - Test-Logic-Reset loads pattern 01 as well
// - Readout LSB first, one bit per falling edge
// - Decode 000 EXTEST, 011 SAMPLE, 111 BYPASS
// - BYPASS puts one-bit register in Shift-DR path
// - BYPASS leaves normal device operation untouched
// - Test-Logic-Reset makes BYPASS current instruction
// - EXTEST puts boundary register in Shift-DR path
// - EXTEST drives output pins from boundary register
// - EXTEST outputs update on system clock after Update-DR falling edge
// - EXTEST captures input pins on Capture-DR rise
// - SAMPLE/PRELOAD never disturbs device or external logic
// - SAMPLE snapshots all pin inputs and outputs
// - Serial out driven only in Shift-IR/DR states
// - Update-IR falling edge latches new instruction
// - Shift-IR advances one bit per rising edge
// - Test reset pin asynchronously forces Test-Logic-Reset
`default_nettype none

module jird_top (
  // System clock and reset
  input wire logic clock,
  input wire logic rst,
  // Test access pins
  input wire logic testClockPin,
  input wire logic testResetN,
  input wire logic testModeSelect,
  input wire logic testSerialIn,
  output logic testSerialOut,
  output logic testSerialOutOe,
  // Device pins and core logic
  input wire logic [jird_pkg::PIN_IN_W-1:0] pinIn,
  input wire logic [jird_pkg::PIN_OUT_W-1:0] coreOut,
  output logic [jird_pkg::PIN_OUT_W-1:0] pinOut
);

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  jird_pkg::jird_rise_s rise;
  jird_pkg::jird_rise_s next_rise;
  jird_pkg::jird_fall_s fall;
  jird_pkg::jird_fall_s next_fall;
  jird_pkg::jird_sys_s sys;
  jird_pkg::jird_sys_s next_sys;

  // Decoded view of the current instruction
  logic selExtest;
  logic selSample;
  logic selBoundary;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  // Anything not EXTEST or SAMPLE/PRELOAD falls back to bypass, so
  // the chain length is always known to the tester
  always_comb begin
    selExtest = (fall.irLatch == jird_pkg::INS_EXTEST);
    selSample = (fall.irLatch == jird_pkg::INS_SAMPLE);
    selBoundary = selExtest | selSample;
  end

  // ----------------------------------------------------------------
  // Controller next state, rising test clock
  // ----------------------------------------------------------------
  always_comb begin
    next_rise = rise;
    case (rise.tap)
      jird_pkg::TAP_RESET: begin
        next_rise.tap = testModeSelect ? jird_pkg::TAP_RESET
                                       : jird_pkg::TAP_IDLE;
      end
      jird_pkg::TAP_IDLE: begin
        next_rise.tap = testModeSelect ? jird_pkg::TAP_SEL_DR
                                       : jird_pkg::TAP_IDLE;
      end
      jird_pkg::TAP_SEL_DR: begin
        next_rise.tap = testModeSelect ? jird_pkg::TAP_SEL_IR
                                       : jird_pkg::TAP_CAP_DR;
      end
      jird_pkg::TAP_CAP_DR: begin
        next_rise.tap = testModeSelect ? jird_pkg::TAP_EXIT1_DR
                                       : jird_pkg::TAP_SHIFT_DR;
      end
      jird_pkg::TAP_SHIFT_DR: begin
        next_rise.tap = testModeSelect ? jird_pkg::TAP_EXIT1_DR
                                       : jird_pkg::TAP_SHIFT_DR;
      end
      jird_pkg::TAP_EXIT1_DR: begin
        next_rise.tap = testModeSelect ? jird_pkg::TAP_UPD_DR
                                       : jird_pkg::TAP_PAUSE_DR;
      end
      jird_pkg::TAP_PAUSE_DR: begin
        next_rise.tap = testModeSelect ? jird_pkg::TAP_EXIT2_DR
                                       : jird_pkg::TAP_PAUSE_DR;
      end
      jird_pkg::TAP_EXIT2_DR: begin
        next_rise.tap = testModeSelect ? jird_pkg::TAP_UPD_DR
                                       : jird_pkg::TAP_SHIFT_DR;
      end
      jird_pkg::TAP_UPD_DR: begin
        next_rise.tap = testModeSelect ? jird_pkg::TAP_SEL_DR
                                       : jird_pkg::TAP_IDLE;
      end
      jird_pkg::TAP_SEL_IR: begin
        next_rise.tap = testModeSelect ? jird_pkg::TAP_RESET
                                       : jird_pkg::TAP_CAP_IR;
      end
      jird_pkg::TAP_CAP_IR: begin
        next_rise.tap = testModeSelect ? jird_pkg::TAP_EXIT1_IR
                                       : jird_pkg::TAP_SHIFT_IR;
      end
      jird_pkg::TAP_SHIFT_IR: begin
        next_rise.tap = testModeSelect ? jird_pkg::TAP_EXIT1_IR
                                       : jird_pkg::TAP_SHIFT_IR;
      end
      jird_pkg::TAP_EXIT1_IR: begin
        next_rise.tap = testModeSelect ? jird_pkg::TAP_UPD_IR
                                       : jird_pkg::TAP_PAUSE_IR;
      end
      jird_pkg::TAP_PAUSE_IR: begin
        next_rise.tap = testModeSelect ? jird_pkg::TAP_EXIT2_IR
                                       : jird_pkg::TAP_PAUSE_IR;
      end
      jird_pkg::TAP_EXIT2_IR: begin
        next_rise.tap = testModeSelect ? jird_pkg::TAP_UPD_IR
                                       : jird_pkg::TAP_SHIFT_IR;
      end
      jird_pkg::TAP_UPD_IR: begin
        next_rise.tap = testModeSelect ? jird_pkg::TAP_SEL_DR
                                       : jird_pkg::TAP_IDLE;
      end
      default: begin
        next_rise.tap = jird_pkg::TAP_RESET;
      end
    endcase

    // Pin snapshots pass two flops before any capture reads them
    next_rise.inMeta = pinIn;
    next_rise.inSync = rise.inMeta;
    next_rise.outMeta = sys.pinOut;
    next_rise.outSync = rise.outMeta;

    // Shift stages: capture, shift or hold
    case (rise.tap)
      jird_pkg::TAP_RESET: begin
        next_rise.irShift = jird_pkg::IR_RESET_LOAD;
      end
      jird_pkg::TAP_CAP_IR: begin
        next_rise.irShift = jird_pkg::IR_CAPTURE;
      end
      jird_pkg::TAP_SHIFT_IR: begin
        // Towards the LSB, bit not inverted
        next_rise.irShift = {testSerialIn,
                             rise.irShift[jird_pkg::IR_W-1:1]};
      end
      jird_pkg::TAP_CAP_DR: begin
        if (selBoundary) begin
          // Outputs in the upper half, inputs in the lower half
          next_rise.bsr = {rise.outSync, rise.inSync};
        end else begin
          next_rise.bypassBit = jird_pkg::BYPASS_CAPTURE;
        end
      end
      jird_pkg::TAP_SHIFT_DR: begin
        if (selBoundary) begin
          next_rise.bsr = {testSerialIn,
                           rise.bsr[jird_pkg::BSR_W-1:1]};
        end else begin
          next_rise.bypassBit = testSerialIn;
        end
      end
      default: begin
        // Other states keep both shift stages as they are
        next_rise.irShift = rise.irShift;
      end
    endcase
  end

  // Controller and shift stages; reset pin acts without the clock
  always_ff @(posedge testClockPin or negedge testResetN) begin
    if (!testResetN) begin
      rise <= '0;
      rise.tap <= jird_pkg::TAP_RESET;
      rise.irShift <= jird_pkg::IR_RESET_LOAD;
    end else begin
      rise <= next_rise;
    end
  end

  // ----------------------------------------------------------------
  // Falling test clock: instruction latch, serial out, update
  // ----------------------------------------------------------------
  always_comb begin
    next_fall = fall;
    // Driver on only in the two shift states
    next_fall.tdoOe = (rise.tap == jird_pkg::TAP_SHIFT_IR) |
                      (rise.tap == jird_pkg::TAP_SHIFT_DR);
    if (rise.tap == jird_pkg::TAP_SHIFT_IR) begin
      next_fall.tdo = rise.irShift[0];
    end else if (rise.tap == jird_pkg::TAP_SHIFT_DR) begin
      next_fall.tdo = selBoundary ? rise.bsr[0] : rise.bypassBit;
    end
    // Current instruction moves only in these two states
    if (rise.tap == jird_pkg::TAP_RESET) begin
      next_fall.irLatch = jird_pkg::INS_BYPASS;
    end else if (rise.tap == jird_pkg::TAP_UPD_IR) begin
      next_fall.irLatch = rise.irShift;
    end
    // Preload and EXTEST both fill the update latch; it reaches
    // the pins only while EXTEST is current
    if (rise.tap == jird_pkg::TAP_UPD_DR && selBoundary) begin
      next_fall.updLatch =
        rise.bsr[jird_pkg::BSR_W-1:jird_pkg::PIN_IN_W];
      next_fall.updToggle = ~fall.updToggle;
    end
    next_fall.extest = (next_fall.irLatch == jird_pkg::INS_EXTEST);
  end

  // Falling-edge register, reset with the controller
  always_ff @(negedge testClockPin or negedge testResetN) begin
    if (!testResetN) begin
      fall <= '0;
      fall.irLatch <= jird_pkg::INS_BYPASS;
    end else begin
      fall <= next_fall;
    end
  end

  // ----------------------------------------------------------------
  // System clock: mode and update crossing, pin drive
  // ----------------------------------------------------------------
  // The update word is held stable between toggles, so it is safe
  // to take once the synchronised toggle shows a change
  always_comb begin
    next_sys = sys;
    next_sys.modeMeta = fall.extest;
    next_sys.modeSync = sys.modeMeta;
    next_sys.togMeta = fall.updToggle;
    next_sys.togSync = sys.togMeta;
    next_sys.togSeen = sys.togSync;
    if (sys.togSync != sys.togSeen) begin
      next_sys.held = fall.updLatch;
    end
    // Core drives the pins unless EXTEST owns them
    if (sys.modeSync) begin
      next_sys.pinOut = sys.held;
    end else begin
      next_sys.pinOut = coreOut;
    end
  end

  // System register, synchronous reset
  always_ff @(posedge clock) begin
    if (rst) begin
      sys <= '0;
    end else begin
      sys <= next_sys;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, straight from flops
  // ----------------------------------------------------------------
  always_comb begin
    testSerialOut = fall.tdo;
    testSerialOutOe = fall.tdoOe;
    pinOut = sys.pinOut;
  end

endmodule // jird_top

`default_nettype wire

// File: sim/jird_tester.sv
`default_nettype none

// ----------------------------------------------------------------
// Boundary-scan tester: test clock runs only within frames
// ----------------------------------------------------------------
module jird_tester (
  // Test access pins driven
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trstN,
  // Test access pins observed
  input wire logic tdo,
  input wire logic tdoOe
);
  timeunit 1ns;
  timeprecision 100ps;

  // Clock parked low, test logic held in reset until the bench lets go;
  // the reset pin starts high so the reset flops see a real falling edge
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trstN = 1'b1;
    #1;
    trstN = 1'b0;
  end

  // Test reset pin level, changed by the bench only between frames
  task automatic setReset(input logic level);
    trstN = level;
  endtask

  // One 6 ns test clock; serial out is read just before the rising edge
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #3;
    o = tdo;
    tck = 1'b1;
    #3;
    tck = 1'b0;
  endtask

  // Idle to shift, n bits first bit first, exit on last bit, update, idle
  task automatic scan(input logic ir, input int n, input logic [23:0] din,
      output logic [23:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    if (ir) begin
      step(1'b1, 1'b0, o);
    end
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    // No pull-up on serial in, so a stale level must not look valid
    tdi = ~tdi;
  endtask
endmodule // jird_tester

`default_nettype wire

// File: sim/jird_top_assertions.sv
`default_nettype none

// ----------------------------------------------------------------
// Port checker for the serial out driver, test reset and pin source
// ----------------------------------------------------------------
module jird_assertions (
  // Clocks and resets
  input wire logic clock,
  input wire logic rst,
  input wire logic testClockPin,
  input wire logic testResetN,
  // Test access pins
  input wire logic testModeSelect,
  input wire logic testSerialIn,
  input wire logic testSerialOut,
  input wire logic testSerialOutOe,
  // Device pins
  input wire logic [jird_pkg::PIN_IN_W-1:0] pinIn,
  input wire logic [jird_pkg::PIN_OUT_W-1:0] coreOut,
  input wire logic [jird_pkg::PIN_OUT_W-1:0] pinOut
);
  // Five mode-select highs always land in reset; long test reset gives bypass
  sequence s_fiveHigh;
    testModeSelect [*5];
  endsequence
  sequence s_trstHeld;
    !testResetN [*5];
  endsequence

  // Serial out driver follows the shift states only
  property p_oeEntry;
    @(posedge testClockPin) disable iff (!testResetN)
      testSerialOutOe |-> !$past(testModeSelect);
  endproperty
  a_oeEntry: assert property (p_oeEntry) else $error("serial out on outside shift");
  property p_oeHold;
    @(posedge testClockPin) disable iff (!testResetN)
      testSerialOutOe && !testModeSelect |=> testSerialOutOe;
  endproperty
  a_oeHold: assert property (p_oeHold) else $error("serial out dropped in shift");
  property p_oeExit;
    @(posedge testClockPin) disable iff (!testResetN)
      testSerialOutOe && testModeSelect |=> !testSerialOutOe;
  endproperty
  a_oeExit: assert property (p_oeExit) else $error("serial out kept after exit");
  property p_tlrQuiet;
    @(posedge testClockPin) disable iff (!testResetN) s_fiveHigh |=> !testSerialOutOe;
  endproperty
  a_tlrQuiet: assert property (p_tlrQuiet) else $error("serial out on after reset");
  property p_resetOe;
    @(posedge clock) disable iff (rst) !testResetN |-> !testSerialOutOe;
  endproperty
  a_resetOe: assert property (p_resetOe) else $error("serial out on in test reset");
  property p_resetTdo;
    @(posedge clock) disable iff (rst) !testResetN |-> !testSerialOut;
  endproperty
  a_resetTdo: assert property (p_resetTdo) else $error("serial out high in reset");
  property p_bypassPins;
    @(posedge clock) disable iff (rst) s_trstHeld |=> pinOut == $past(coreOut);
  endproperty
  a_bypassPins: assert property (p_bypassPins) else $error("pins not from core");
  // Reset of the pin register itself, so no disable here
  property p_rstPins;
    @(posedge clock) rst |=> pinOut == '0;
  endproperty
  a_rstPins: assert property (p_rstPins) else $error("pins not cleared by reset");
endmodule // jird_assertions

bind jird_top jird_assertions jird_assertions_inst (.clock(clock), .rst(rst),
  .testClockPin(testClockPin), .testResetN(testResetN), .testModeSelect(testModeSelect),
  .testSerialIn(testSerialIn), .testSerialOut(testSerialOut),
  .testSerialOutOe(testSerialOutOe), .pinIn(pinIn), .coreOut(coreOut), .pinOut(pinOut));

`default_nettype wire

// File: sim/test_jird_top.sv
`default_nettype none

// ----------------------------------------------------------------
// Bench: instruction rows, then resets in mid-run
// ----------------------------------------------------------------
module test_jird_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [2:0] code; logic [4:0] len;} jird_row_s;
  // Preload under SAMPLE comes before EXTEST; unused codes give bypass
  jird_row_s rows [9] = '{'{jird_pkg::INS_BYPASS, 5'h01}, '{jird_pkg::INS_SAMPLE, 5'h10},
    '{jird_pkg::INS_EXTEST, 5'h10}, '{3'h1, 5'h01}, '{3'h2, 5'h01}, '{3'h4, 5'h01},
    '{3'h5, 5'h01}, '{3'h6, 5'h01}, '{jird_pkg::INS_SAMPLE, 5'h10}};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic tck, tms, tdi, trstN, tdo, tdoOe, o;
  logic [7:0] pinIn, coreOut, pinOut, held, seq;
  logic [23:0] q;
  int n_mismatch = 0;
  int compares = 0;

  // 25 MHz system clock
  always #20 clock = ~clock;

  jird_tester jird_tester_inst (.tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN),
    .tdo(tdo), .tdoOe(tdoOe));
  jird_top jird_top_inst (.clock(clock), .rst(rst), .testClockPin(tck), .testResetN(trstN),
    .testModeSelect(tms), .testSerialIn(tdi), .testSerialOut(tdo), .testSerialOutOe(tdoOe),
    .pinIn(pinIn), .coreOut(coreOut), .pinOut(pinOut));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Inputs move 1 ns after the system clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Six-bit scan: complement then new code in, the captured pattern and the complement out
  task automatic scanIr(input logic [2:0] code);
    jird_tester_inst.scan(1'b1, 6, {18'h0, code, ~code}, q);
    check(q, {18'h0, ~code, jird_pkg::IR_CAPTURE});
    tick(8);
  endtask

  // 24-bit data scan: the captured word leaves first, then the chain delays by len
  task automatic scanDr(input logic [4:0] len, input logic [7:0] pins);
    logic [23:0] d;
    logic [15:0] cap;
    seq = seq + 8'h2B;
    d = 24'hC35A96 ^ {3{seq}};
    cap = (len == 5'h10) ? {pins, pinIn} : {15'h0, jird_pkg::BYPASS_CAPTURE};
    jird_tester_inst.scan(1'b0, 24, d, q);
    check(q, 24'((d << len) | cap));
    if (len == 5'h10) begin
      held = d[23:16];
    end
    tick(8);
  endtask

  // Watchdog in case a scan never returns
  initial begin
    #2ms;
    n_mismatch++;
    final_report();
  end

  initial begin
    pinIn = 8'h3C;
    coreOut = 8'h00;
    held = 8'h00;
    seq = 8'h00;
    tick(6);
    rst = 1'b0;
    coreOut = 8'h5A;
    tick(8);
    check(24'(pinOut), 24'(coreOut));
    $display("Startup reset done");
    jird_tester_inst.setReset(1'b1);
    jird_tester_inst.step(1'b0, 1'b0, o);
    // Ordinary cases: every code, with pins and core values moving per row
    for (int i = 0; i < 9; i++) begin
      coreOut = 8'(8'h21 * i + 8'h0F);
      pinIn = ~coreOut;
      scanIr(rows[i].code);
      q[7:0] = (rows[i].code == jird_pkg::INS_EXTEST) ? held : coreOut;
      check(24'(pinOut), 24'(q[7:0]));
      scanDr(rows[i].len, q[7:0]);
      check(24'(pinOut), 24'((rows[i].code == jird_pkg::INS_EXTEST) ? held : coreOut));
      $display("Row %0d done", i);
    end
    // Test reset pin in the middle of EXTEST
    scanIr(jird_pkg::INS_EXTEST);
    jird_tester_inst.setReset(1'b0);
    tick(8);
    check(24'(pinOut), 24'(coreOut));
    jird_tester_inst.setReset(1'b1);
    jird_tester_inst.step(1'b0, 1'b0, o);
    scanDr(5'h01, coreOut);
    $display("Test reset pin done");
    // Five mode-select highs out of EXTEST
    scanIr(jird_pkg::INS_EXTEST);
    repeat (5) jird_tester_inst.step(1'b1, 1'b0, o);
    jird_tester_inst.step(1'b0, 1'b0, o);
    tick(8);
    check(24'(pinOut), 24'(coreOut));
    scanDr(5'h01, coreOut);
    $display("Mode-select reset done");
    // System reset in mid-run clears the pins
    rst = 1'b1;
    tick(2);
    check(24'(pinOut), 24'h0);
    rst = 1'b0;
    $display("System reset done");
    final_report();
  end
endmodule // test_jird_top

`default_nettype wire
